// ==== design/cdr_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "cdr_regs.vh"

module cdr_ctrl (
  input  wire        clk_sys_i,          // System clock, 25 MHz
  input  wire        rst_n_i,            // Async reset, active low
  input  wire        scl_i,              // Serial clock level
  input  wire        sda_i,              // Serial data line level
  output reg         sda_o,              // Serial data drive value
  output reg         sda_oe_o,           // Serial data drive enable
  input  wire        addr_select_pin_i,  // Slave address bit 5
  input  wire [15:0] data_err_ppm_i,     // VCO vs data error, ppm
  input  wire [15:0] ref_err_ppm_i,      // Divided VCO vs divided ref, ppm
  input  wire        squelch_i,          // Squelch pin
  input  wire        data_in_i,          // Retimed data
  input  wire        rec_clk_i,          // Recovered clock
  output reg         lock_lost_out_o,    // Loss-of-lock pin
  output reg         freq_acq_o,         // Frequency loop active
  output reg         ref_acq_o,          // Acquiring against reference
  output reg  [1:0]  ref_range_o,        // Reference range field
  output reg  [3:0]  ref_div_o,          // Data-to-reference ratio field
  output reg         data_out_pos_o,     // Data output, true
  output reg         data_out_neg_o,     // Data output, complement
  output reg         rec_clk_out_pos_o,  // Clock output, true
  output reg         rec_clk_out_neg_o   // Clock output, complement
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_SUB  = 4'h3;
  localparam [3:0] ST_SACK = 4'h4;
  localparam [3:0] ST_WR   = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RD   = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  reg  [7:0]  ctrl_a;
  reg  [7:0]  ctrl_b;
  reg  [7:0]  ctrl_c;
  reg  [7:0]  ctrl_b_prev;
  reg         locked;
  reg         sticky;
  reg  [15:0] err_hold;
  reg         scl_q;
  reg         sda_q;
  reg  [3:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shift;
  reg  [2:0]  sub;
  reg         master_nack;

  wire [15:0] err_sel;
  wire        restart;
  wire        lose;
  wire        sticky_clr;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire [6:0]  my_addr;
  reg  [7:0]  rd_word;
  reg         sq_data;
  reg         sq_clk;

  // Lock detector compares against data or divided reference
  assign err_sel = ctrl_a[`CDR_CA_LOCK_REF] ? ref_err_ppm_i : data_err_ppm_i;  // see RQ3
  assign restart = ctrl_b_prev[`CDR_CB_ACQ_RESTART] & ~ctrl_b[`CDR_CB_ACQ_RESTART];  // see RQ22
  assign lose = locked & ((err_sel > `CDR_UNLOCK_PPM) | restart);  // see RQ2
  assign sticky_clr = ctrl_b_prev[`CDR_CB_STICKY_CLR] & ~ctrl_b[`CDR_CB_STICKY_CLR];  // see RQ7

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked <= 1'b0;
      sticky <= 1'b0;
      ctrl_b_prev <= `CDR_CTRL_B_RST;
      err_hold <= 16'h0000;
    end else begin
      ctrl_b_prev <= ctrl_b;
      // Error readback trails the detector by a cycle
      err_hold <= err_sel;
      if (lose) begin
        locked <= 1'b0;  // see RQ2
      end else if (!locked && !restart && err_sel <= `CDR_LOCK_PPM) begin
        locked <= 1'b1;  // see RQ1
      end
      // Set wins over a clear in the same cycle
      if (lose) begin
        sticky <= 1'b1;  // see RQ6
      end else if (sticky_clr) begin
        sticky <= 1'b0;  // see RQ7
      end
    end
  end

  // Loop steering, pin and squelched outputs
  always @* begin
    if (ctrl_c[`CDR_CC_SQ_MODE]) begin
      sq_data = squelch_i;  // see RQ10
      sq_clk = ~squelch_i;  // see RQ10
    end else begin
      sq_data = squelch_i;  // see RQ9
      sq_clk = squelch_i;  // see RQ9
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_lost_out_o <= 1'b1;
      freq_acq_o <= 1'b1;
      ref_acq_o <= 1'b0;
      ref_range_o <= 2'h0;
      ref_div_o <= 4'h0;
      data_out_pos_o <= 1'b0;
      data_out_neg_o <= 1'b1;
      rec_clk_out_pos_o <= 1'b0;
      rec_clk_out_neg_o <= 1'b1;
    end else begin
      lock_lost_out_o <= ctrl_b[`CDR_CB_PIN_STICKY] ? sticky : ~locked;  // see RQ8
      freq_acq_o <= ~locked;  // see RQ1
      ref_acq_o <= ~locked & ctrl_a[`CDR_CA_LOCK_REF];  // see RQ5
      ref_range_o <= ctrl_a[7:6];
      ref_div_o <= ctrl_a[5:2];
      // Squelched pair rests at pos low, neg high
      data_out_pos_o <= data_in_i & ~sq_data;
      data_out_neg_o <= ~data_in_i | sq_data;
      rec_clk_out_pos_o <= rec_clk_i & ~sq_clk;
      rec_clk_out_neg_o <= ~rec_clk_i | sq_clk;
    end
  end

  // Two-wire slave
  assign scl_rise = ~scl_q & scl_i;
  assign scl_fall = scl_q & ~scl_i;
  assign start_det = scl_q & scl_i & sda_q & ~sda_i;
  assign stop_det = scl_q & scl_i & ~sda_q & sda_i;
  assign my_addr = {`CDR_ADDR_MSB, addr_select_pin_i, `CDR_ADDR_LOW};  // see RQ11

  // Read source for the current subaddress
  always @* begin
    case (sub)
      `CDR_SUB_CTRL_A: rd_word = ctrl_a;
      `CDR_SUB_CTRL_B: rd_word = ctrl_b;
      `CDR_SUB_CTRL_C: rd_word = ctrl_c;
      `CDR_SUB_MISC:   rd_word = {3'h0, sticky, 3'h0, ~locked};
      `CDR_SUB_ERR_LO: rd_word = err_hold[7:0];
      `CDR_SUB_ERR_HI: rd_word = err_hold[15:8];
      default:         rd_word = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // History reset high: no false edge after reset
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      sub <= 3'h0;
      master_nack <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      ctrl_a <= `CDR_CTRL_A_RST;
      ctrl_b <= `CDR_CTRL_B_RST;
      ctrl_c <= `CDR_CTRL_C_RST;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      sda_o <= 1'b0;
      // Start or stop aborts any phase at once
      if (start_det) begin
        state <= ST_ADDR;  // see RQ18
        bit_cnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;  // see RQ18
        sda_oe_o <= 1'b0;
      end else begin
        if (scl_rise && (state == ST_ADDR || state == ST_SUB || state == ST_WR)) begin
          shift <= {shift[6:0], sda_i};  // see RQ13
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (scl_rise && state == ST_RD) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        // Master answer taken on the ninth rising edge
        if (scl_rise && state == ST_RACK) begin
          master_nack <= sda_i;  // see RQ21
        end
        // Drive changes only after a falling sample
        if (scl_fall) begin
          case (state)
            ST_ADDR: begin
              if (bit_cnt == 4'h8) begin
                if (shift[7:1] == my_addr) begin
                  state <= ST_AACK;
                  sda_oe_o <= 1'b1;  // see RQ14
                end else begin
                  state <= ST_IDLE;  // see RQ14
                end
              end
            end
            ST_SUB: begin
              if (bit_cnt == 4'h8) begin
                if (shift < `CDR_NUM_SUB) begin
                  sub <= shift[2:0];  // see RQ15
                  state <= ST_SACK;
                  sda_oe_o <= 1'b1;
                end else begin
                  state <= ST_IDLE;  // see RQ20
                end
              end
            end
            ST_WR: begin
              if (bit_cnt == 4'h8) begin
                state <= ST_WACK;
                sda_oe_o <= 1'b1;
              end
            end
            ST_AACK: begin
              bit_cnt <= 4'h0;
              // Direction bit still sits in shift[0]
              if (shift[0]) begin
                state <= ST_RD;  // see RQ12
                shift <= {rd_word[6:0], 1'b0};  // see RQ23
                sda_oe_o <= ~rd_word[7];
              end else begin
                state <= ST_SUB;  // see RQ12
                sda_oe_o <= 1'b0;
              end
            end
            ST_SACK: begin
              bit_cnt <= 4'h0;
              state <= ST_WR;
              sda_oe_o <= 1'b0;
            end
            ST_WACK: begin
              bit_cnt <= 4'h0;
              state <= ST_WR;
              sda_oe_o <= 1'b0;
              // Writes to read-only slots are dropped
              case (sub)
                `CDR_SUB_CTRL_A: ctrl_a <= shift;  // see RQ23
                `CDR_SUB_CTRL_B: ctrl_b <= shift;  // see RQ23
                `CDR_SUB_CTRL_C: ctrl_c <= shift;  // see RQ23
                default: ;
              endcase
              if (sub != `CDR_SUB_TOP) begin
                sub <= sub + 3'h1;  // see RQ16
              end
            end
            ST_RD: begin
              if (bit_cnt == 4'h8) begin
                state <= ST_RACK;
                sda_oe_o <= 1'b0;
              end else begin
                sda_oe_o <= ~shift[7];
                shift <= {shift[6:0], 1'b0};
              end
            end
            ST_RACK: begin
              bit_cnt <= 4'h0;
              if (master_nack) begin
                state <= ST_IDLE;  // see RQ21
                sda_oe_o <= 1'b0;
              end else begin
                state <= ST_RD;
                // Past the top slot the last word repeats
                if (sub != `CDR_SUB_TOP) begin
                  sub <= sub + 3'h1;  // see RQ16
                  shift <= {rd_word_next(sub, ctrl_a, ctrl_b, ctrl_c, sticky, locked, err_hold), 1'b0};
                  sda_oe_o <= ~rd_bit7(sub, ctrl_a, ctrl_b, ctrl_c, sticky, locked, err_hold);
                end else begin
                  shift <= {rd_word[6:0], 1'b0};  // see RQ21
                  sda_oe_o <= ~rd_word[7];
                end
              end
            end
            default: begin
              sda_oe_o <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Contents of the register at the given subaddress
  function [7:0] word_at;
    input [2:0]  s;
    input [7:0]  a;
    input [7:0]  b;
    input [7:0]  c;
    input        st;
    input        lk;
    input [15:0] e;
    begin
      case (s)
        `CDR_SUB_CTRL_A: word_at = a;
        `CDR_SUB_CTRL_B: word_at = b;
        `CDR_SUB_CTRL_C: word_at = c;
        `CDR_SUB_MISC:   word_at = {3'h0, st, 3'h0, ~lk};
        `CDR_SUB_ERR_LO: word_at = e[7:0];
        `CDR_SUB_ERR_HI: word_at = e[15:8];
        default:         word_at = 8'h00;
      endcase
    end
  endfunction

  // Low seven bits of the next word, behind bit 7
  function [6:0] rd_word_next;
    input [2:0]  s;
    input [7:0]  a;
    input [7:0]  b;
    input [7:0]  c;
    input        st;
    input        lk;
    input [15:0] e;
    reg   [7:0]  w;
    begin
      w = word_at(s + 3'h1, a, b, c, st, lk, e);
      rd_word_next = w[6:0];
    end
  endfunction

  // First bit out of the next word
  function rd_bit7;
    input [2:0]  s;
    input [7:0]  a;
    input [7:0]  b;
    input [7:0]  c;
    input        st;
    input        lk;
    input [15:0] e;
    reg   [7:0]  w;
    begin
      w = word_at(s + 3'h1, a, b, c, st, lk, e);
      rd_bit7 = w[7];
    end
  endfunction

endmodule // cdr_ctrl

`default_nettype wire

// ==== design/cdr_regs.vh ====
// Notes on behaviour
// RQ1 - Release loss-of-lock within 250 ppm, then track
// RQ2 - Reassert above 1000 ppm; hold until 250
// RQ3 - Control A bit 0 selects reference lock
// RQ4 - Host programs range and divide fields
// RQ5 - Reference mode reacquires against reference clock
// RQ6 - Sticky flag misc bit 4 on loss
// RQ7 - Control B bit 6 one-then-zero clears sticky
// RQ8 - Control B bit 7 puts sticky on pin
// RQ9 - Mode 0: squelch gates data and clock
// RQ10 - Mode 1: high squelches data, low clock
// RQ11 - Address: msb one, bit5 pin, rest zero
// RQ12 - First byte lsb one reads, zero writes
// RQ13 - Master starts, sends eight bits msb first
// RQ14 - Acknowledge own address, else go idle
// RQ15 - Second byte is the starting subaddress
// RQ16 - Subaddress increments after every data byte; code holds it at 7 and after a master-nacked read byte
// RQ17 - Master ends each transfer with stop
// RQ18 - Start or stop anywhere resets the slave
// RQ19 - One start, stop, or stop-start per high
// RQ20 - Invalid subaddress: no acknowledge, go idle
// RQ21 - Reads past top repeat the top register
// RQ22 - Control B bit 5 one-then-zero restarts acquisition
// RQ23 - Writes land after ack; reads load per byte
`ifndef CDR_REGS_VH
`define CDR_REGS_VH

`define CDR_SUB_CTRL_A     3'h0
`define CDR_SUB_CTRL_B     3'h1
`define CDR_SUB_CTRL_C     3'h2
`define CDR_SUB_MISC       3'h3
`define CDR_SUB_ERR_LO     3'h4
`define CDR_SUB_ERR_HI     3'h5
`define CDR_SUB_TOP        3'h7
`define CDR_NUM_SUB        8'h08

`define CDR_CA_LOCK_REF    0
`define CDR_CB_ACQ_RESTART 5
`define CDR_CB_STICKY_CLR  6
`define CDR_CB_PIN_STICKY  7
`define CDR_CC_SQ_MODE     1
`define CDR_MISC_STICKY    4
`define CDR_MISC_LIVE      0

`define CDR_CTRL_A_RST     8'h00
`define CDR_CTRL_B_RST     8'h00
`define CDR_CTRL_C_RST     8'h00

`define CDR_LOCK_PPM       16'd250
`define CDR_UNLOCK_PPM     16'd1000

`define CDR_ADDR_MSB       1'b1
`define CDR_ADDR_LOW       5'h00

`endif

// ==== tb/cdr_ctrl_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module cdr_ctrl_props (
  input wire logic        clk_sys_i,       // Clock
  input wire logic        rst_n_i,         // Reset
  input wire logic        scl_i,           // Bus clock
  input wire logic        sda_i,           // Bus data
  input wire logic        sda_oe_o,        // Data pull
  input wire logic [15:0] data_err_ppm_i,  // Data error
  input wire logic [15:0] ref_err_ppm_i,   // Ref error
  input wire logic        squelch_i,       // Squelch
  input wire logic        data_in_i,       // Data in
  input wire logic        lock_lost_out_o, // Lock pin
  input wire logic        freq_acq_o,      // Acquiring
  input wire logic        ref_acq_o,       // Ref acquiring
  input wire logic        data_out_pos_o,  // Data true
  input wire logic        data_out_neg_o   // Data inverse
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  lock_norm_a: assert property ((freq_acq_o && !ref_acq_o && data_err_ppm_i <= 16'd250) [*2]
    |-> ##[0:2] !freq_acq_o) else $error("no lock on small data error");
  lock_ref_a: assert property ((ref_acq_o && ref_err_ppm_i <= 16'd250) [*2]
    |-> ##[0:2] !ref_acq_o) else $error("no lock on small ref error");
  unlock_big_a: assert property (!freq_acq_o && data_err_ppm_i > 16'd1000 && ref_err_ppm_i > 16'd1000
    |-> ##[1:3] freq_acq_o) else $error("no unlock on large error");
  lol_rise_a: assert property ($rose(freq_acq_o) |-> ##[0:3] lock_lost_out_o)
    else $error("lock pin not raised");
  sq_high_a: assert property (squelch_i |=> !data_out_pos_o && data_out_neg_o)
    else $error("data not squelched");
  sq_low_a: assert property (!squelch_i && data_in_i |=> data_out_pos_o && !data_out_neg_o)
    else $error("data squelched while low");
  drive_phase_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed with clock high");
  stop_idle_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*8])
    else $error("driving after stop");
  cover property ($fell(freq_acq_o));
  cover property ($rose(sda_oe_o));
  cover property ($rose(ref_acq_o));
endmodule // cdr_ctrl_props
bind cdr_ctrl cdr_ctrl_props cdr_ctrl_props_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
  .data_err_ppm_i(data_err_ppm_i), .ref_err_ppm_i(ref_err_ppm_i), .squelch_i(squelch_i),
  .data_in_i(data_in_i), .lock_lost_out_o(lock_lost_out_o), .freq_acq_o(freq_acq_o),
  .ref_acq_o(ref_acq_o), .data_out_pos_o(data_out_pos_o), .data_out_neg_o(data_out_neg_o)
);
`default_nettype wire

// ==== tb/cdr_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module cdr_host (
  input  wire logic clk_sys_i, // Clock
  input  wire logic sda_i,     // Resolved data
  output var  logic scl_o,     // Bus clock
  output var  logic sda_o      // Low pulls line
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Also a repeated start; one start per clock high
  task automatic start;
    sda_o = 1'b1;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    sda_o = 1'b0;
    wt(3);
    scl_o = 1'b0;
    wt(2);
  endtask
  task automatic stop;
    sda_o = 1'b0;
    wt(2);
    scl_o = 1'b1;
    wt(3);
    sda_o = 1'b1;
    wt(3);
  endtask
  task automatic bit1(input logic b, output logic r);
    sda_o = b;
    wt(3);
    scl_o = 1'b1;
    wt(2);
    r = sda_i;
    wt(2);
    scl_o = 1'b0;
    wt(1);
  endtask
  // Eight bits msb first, ninth is ack slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      bit1(d[i], q[i]);
    end
  endtask
endmodule // cdr_host
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        scl, sda_m, sda_i, sda_o, sda_oe_o, pin;
  logic [15:0] derr, rerr;
  logic        sq, din, rclk;
  logic        lock_lost_out, facq, racq, dp, dn, cp, cn;
  logic [1:0]  rng;
  logic [3:0]  rdiv;
  logic [8:0]  q;
  int          err_total = 0, n_compared = 0;
  logic [16:0] lv [6] = '{{16'd251, 1'b1}, {16'd250, 1'b0}, {16'd1000, 1'b0},
                          {16'd1001, 1'b1}, {16'd500, 1'b1}, {16'd250, 1'b0}};
  assign sda_i = sda_m & ~(sda_oe_o & ~sda_o);
  cdr_ctrl cdr_ctrl_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_i(pin), .data_err_ppm_i(derr),
    .ref_err_ppm_i(rerr), .squelch_i(sq), .data_in_i(din), .rec_clk_i(rclk),
    .lock_lost_out_o(lock_lost_out), .freq_acq_o(facq), .ref_acq_o(racq), .ref_range_o(rng),
    .ref_div_o(rdiv), .data_out_pos_o(dp), .data_out_neg_o(dn), .rec_clk_out_pos_o(cp),
    .rec_clk_out_neg_o(cn));
  cdr_host h (.clk_sys_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl), .sda_o(sda_m));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [8:0] ab(input logic rd);
    return {1'b1, pin, 5'h00, rd, 1'b1};
  endfunction
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    h.start();
    h.xfer(ab(1'b0), q);
    chk("write ack", q[0], 1'b0);
    h.xfer({sub, 1'b1}, q);
    chk("sub ack", q[0], 1'b0);
    foreach (d[i]) begin
      h.xfer({d[i], 1'b1}, q);
      chk("data ack", q[0], 1'b0);
    end
    h.stop();
  endtask
  task automatic rd(input logic [7:0] sub, input logic [7:0] e[$]);
    h.start();
    h.xfer(ab(1'b0), q);
    h.xfer({sub, 1'b1}, q);
    h.start();
    h.xfer(ab(1'b1), q);
    chk("read ack", q[0], 1'b0);
    foreach (e[i]) begin
      h.xfer({8'hff, i == e.size() - 1}, q);
      chk("read data", q[8:1], e[i]);
    end
    h.stop();
  endtask
  initial begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    rst_n_i = 1'b0;
    pin = 1'b0;
    derr = 16'd2000;
    rerr = 16'd2000;
    sq = 1'b0;
    din = 1'b1;
    rclk = 1'b1;
    h.wt(3);
    rst_n_i = 1'b1;
    chk("lock pin", lock_lost_out, 1'b1);
    foreach (lv[i]) begin
      derr = lv[i][16:1];
      h.wt(6);
      chk("lock pin", lock_lost_out, lv[i][0]);
      chk("acquiring", facq, lv[i][0]);
    end
    rd(8'h03, '{8'h10});
    wr(8'h01, '{8'h40});
    wr(8'h01, '{8'h00});
    rd(8'h03, '{8'h00});
    wr(8'h01, '{8'h80});
    derr = 16'd1500;
    h.wt(6);
    derr = 16'd0;
    h.wt(6);
    chk("sticky pin", lock_lost_out, 1'b1);
    wr(8'h01, '{8'hc0});
    wr(8'h01, '{8'h80});
    chk("cleared pin", lock_lost_out, 1'b0);
    wr(8'h01, '{8'h00});
    wr(8'h00, '{8'h14});
    wr(8'h01, '{8'h20});
    wr(8'h01, '{8'h00});
    h.wt(6);
    rd(8'h00, '{8'h14, 8'h00, 8'h00, 8'h10});
    rerr = 16'd0;
    wr(8'h00, '{8'h95, 8'h00, 8'h02});
    rd(8'h00, '{8'h95, 8'h00, 8'h02, 8'h10});
    chk("range", rng, 2'h2);
    chk("divide", rdiv, 4'h5);
    derr = 16'd2000;
    h.wt(6);
    chk("ref lock", lock_lost_out, 1'b0);
    rerr = 16'd2000;
    h.wt(6);
    chk("ref acq", racq, 1'b1);
    chk("ref lost", lock_lost_out, 1'b1);
    rerr = 16'd200;
    h.wt(6);
    chk("ref relock", lock_lost_out, 1'b0);
    chk("ref acq done", racq, 1'b0);
    rd(8'h04, '{8'hc8, 8'h00, 8'h00, 8'h00, 8'h00});
    for (int m = 1; m >= 0; m--) begin
      wr(8'h02, '{8'(m * 2)});
      for (int s = 0; s < 4; s++) begin
        sq = s[0];
        din = s[1];
        rclk = ~s[1];
        h.wt(3);
        chk("data out", {dp, dn}, sq ? 2'b01 : {din, ~din});
        chk("clock out", {cp, cn}, (((m == 1) ? ~sq : sq) ? 2'b01 : {rclk, ~rclk}));
      end
    end
    pin = 1'b1;
    h.start();
    h.xfer({7'h40, 1'b0, 1'b1}, q);
    chk("foreign ack", q[0], 1'b1);
    h.stop();
    h.start();
    h.xfer(ab(1'b0), q);
    h.xfer({8'h08, 1'b1}, q);
    chk("bad sub ack", q[0], 1'b1);
    h.xfer({8'h55, 1'b1}, q);
    h.stop();
    rd(8'h00, '{8'h95});
    h.start();
    h.xfer(ab(1'b0), q);
    h.xfer({8'h02, 1'b1}, q);
    repeat (4) h.bit1(1'b1, q[0]);
    h.stop();
    h.xfer({8'hff, 1'b1}, q);
    h.stop();
    rd(8'h02, '{8'h00});
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
